// ### vco_cal_lock_dither_ctrl.sv
/*
  Oscillator calibration sequencer, lock indicator, auto-squelch and fractional
  divider append control. Assumes the analog calibrator and lock detector sit
  outside and report by level pins; registers are written by per-register strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module vco_cal_lock_dither_ctrl
  import vco_cal_pkg::*;
#(
  parameter int FRAC_W = vco_cal_pkg::KDIV_FRAC_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_frac_ctrl_we,
  input wire logic [vco_cal_pkg::REG_W-1:0] i_frac_ctrl_wdata,
  output logic [vco_cal_pkg::REG_W-1:0] o_frac_ctrl_rdata,
  input wire logic i_vco_ctrl_we,
  input wire logic [vco_cal_pkg::REG_W-1:0] i_vco_ctrl_wdata,
  output logic [vco_cal_pkg::REG_W-1:0] o_vco_ctrl_rdata,
  input wire logic i_out_ctrl_we,
  input wire logic [vco_cal_pkg::REG_W-1:0] i_out_ctrl_wdata,
  output logic [vco_cal_pkg::REG_W-1:0] o_out_ctrl_rdata,
  input wire logic [FRAC_W-1:0] i_kdiv_frac,
  output logic [FRAC_W:0] o_kdiv_frac_eff,
  input wire logic i_cal_done,
  input wire logic i_pll_locked,
  output logic o_cal_start,
  output logic o_cal_to_default,
  output logic o_lock_indicator_n_o,
  output logic o_lock_indicator_n_oe_n,
  output logic o_out_squelch
);
  import vco_cal_pkg::*;

  typedef struct packed {
    cal_state_t fsm;
    logic to_default;
    logic [REG_W-1:0] frac_ctrl;
    logic [REG_W-1:0] out_ctrl;
    logic ld_low;
    logic squelch;
    logic cal_start;
    logic [FRAC_W:0] kdiv_eff;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  logic [SYNC_W-1:0] pins_s;
  logic cal_done_s;
  logic locked_s;
  logic trig_wr;

  // Analog status pins come from outside this clock domain
  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async({i_pll_locked, i_cal_done}),
    .o_sync(pins_s)
  );
  assign cal_done_s = pins_s[0];
  assign locked_s = pins_s[1];

  // Only a one starts a run; a zero is ignored so a run in flight completes
  assign trig_wr = i_vco_ctrl_we && i_vco_ctrl_wdata[VCO_CAL_BIT];

  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.cal_start = 1'b0;
      // Reserved bits are stored as written so read-modify-write keeps them
      if (i_frac_ctrl_we) begin
        st_nxt.frac_ctrl = i_frac_ctrl_wdata;
      end
      if (i_out_ctrl_we) begin
        st_nxt.out_ctrl = i_out_ctrl_wdata;
      end
      unique case (st_r.fsm)
        ST_KICK: begin
          st_nxt.cal_start = 1'b1;
          st_nxt.fsm = ST_CAL;
        end
        ST_CAL: begin
          if (cal_done_s) begin
            st_nxt.fsm = ST_LOCK;
          end
        end
        ST_LOCK: begin
          // Trigger bit clears only once calibrated and locked
          if (locked_s) begin
            st_nxt.fsm = ST_RUN;
            st_nxt.to_default = 1'b0;
          end
        end
        ST_RUN: begin
          // No automatic recalibration on lock loss or retuning: small moves stay in lock
          st_nxt.fsm = ST_RUN;
        end
        default: begin
          st_nxt.fsm = ST_KICK;
        end
      endcase
      if (trig_wr) begin
        st_nxt.fsm = ST_KICK;
      end
      // Indicator follows the next state so a trigger write drops it at once
      st_nxt.ld_low = (st_nxt.fsm != ST_RUN) || !locked_s;
      st_nxt.squelch = st_nxt.out_ctrl[AUTO_SQUELCH_BIT] && st_nxt.ld_low;
      // Appended bit adds one part in 2**(FRAC_W+1) when set, nothing when clear
      st_nxt.kdiv_eff = {i_kdiv_frac, st_nxt.frac_ctrl[FRAC_APPEND_BIT]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r.fsm <= ST_KICK;
      st_r.to_default <= 1'b1;
      st_r.frac_ctrl <= FRAC_CTRL_RST;
      st_r.out_ctrl <= OUT_CTRL_RST;
      st_r.ld_low <= 1'b1;
      st_r.squelch <= 1'b0;
      st_r.cal_start <= 1'b0;
      st_r.kdiv_eff <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_frac_ctrl_rdata = st_r.frac_ctrl;
  assign o_out_ctrl_rdata = st_r.out_ctrl;
  assign o_vco_ctrl_rdata = (st_r.fsm != ST_RUN) ? VCO_CTRL_RST : '0;
  assign o_kdiv_frac_eff = st_r.kdiv_eff;
  assign o_cal_start = st_r.cal_start;
  assign o_cal_to_default = st_r.to_default;
  // Open-drain: only ever pulls low, enable is active low
  assign o_lock_indicator_n_o = 1'b0;
  assign o_lock_indicator_n_oe_n = !st_r.ld_low;
  assign o_out_squelch = st_r.squelch;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_trigger_write;
    i_ce && trig_wr;
  endsequence

  sequence seq_cal_complete;
    i_ce && st_r.fsm == ST_LOCK && locked_s && !trig_wr;
  endsequence

  chk_append_one: assert property (
    i_ce && st_nxt.frac_ctrl[FRAC_APPEND_BIT] |=> o_kdiv_frac_eff[0]
      && o_kdiv_frac_eff[FRAC_W:1] == $past(i_kdiv_frac))
    else $error("appended fraction bit not one");

  chk_append_clear: assert property (
    i_ce && !st_nxt.frac_ctrl[FRAC_APPEND_BIT] |=> o_kdiv_frac_eff == {$past(i_kdiv_frac), 1'b0})
    else $error("fraction altered with append clear");

  chk_reset_cal: assert property (disable iff (1'b0)
    i_sys_rst |=> o_vco_ctrl_rdata[VCO_CAL_BIT] && o_cal_to_default && !o_lock_indicator_n_oe_n)
    else $error("no calibration pending after reset");

  chk_append_rst: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_frac_ctrl_rdata[FRAC_APPEND_BIT])
    else $error("append bit set after reset");

  chk_trig_start: assert property (
    seq_trigger_write |=> o_vco_ctrl_rdata[VCO_CAL_BIT] ##1 (!i_ce || o_cal_start) [*1])
    else $error("trigger write did not start calibration");

  chk_trig_clear: assert property (
    seq_cal_complete |=> !o_vco_ctrl_rdata[VCO_CAL_BIT] && o_lock_indicator_n_oe_n)
    else $error("trigger not cleared on lock");

  chk_trig_hold: assert property (
    $fell(o_vco_ctrl_rdata[VCO_CAL_BIT]) |-> $past(locked_s) && $past(st_r.fsm) == ST_LOCK)
    else $error("trigger cleared before lock");

  chk_ld_recal: assert property (
    seq_trigger_write |=> !o_lock_indicator_n_oe_n)
    else $error("lock indicator not low on recalibration");

  chk_ld_unlock: assert property (
    i_ce && !locked_s |=> !o_lock_indicator_n_oe_n)
    else $error("lock indicator released while unlocked");

  chk_squelch_on: assert property (
    i_ce && st_nxt.out_ctrl[AUTO_SQUELCH_BIT] && !locked_s |=> o_out_squelch)
    else $error("output not squelched while unlocked");

  chk_squelch_off: assert property (
    i_ce && !st_nxt.out_ctrl[AUTO_SQUELCH_BIT] |=> !o_out_squelch)
    else $error("squelch with auto-squelch disabled");

  chk_zero_write: assert property (
    i_ce && st_r.fsm == ST_CAL && !cal_done_s && i_vco_ctrl_we
      && !i_vco_ctrl_wdata[VCO_CAL_BIT] |=> o_vco_ctrl_rdata[VCO_CAL_BIT] && st_r.fsm == ST_CAL)
    else $error("zero write disturbed calibration");
endmodule // vco_cal_lock_dither_ctrl
`default_nettype wire

// ### vco_cal_pkg.sv
/*
  Constants shared by the oscillator calibration and lock control block.
  Assumes a single 100 MHz clock domain and registers reached by per-register strobes.
*/
package vco_cal_pkg;
  localparam int KDIV_FRAC_W = 24;
  localparam int REG_W = 8;
  localparam int FRAC_APPEND_BIT = 5;
  localparam int VCO_CAL_BIT = 0;
  localparam int AUTO_SQUELCH_BIT = 5;
  localparam logic [7:0] FRAC_CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] VCO_CTRL_RST = 8'h01;
  localparam int SYNC_W = 2;
  typedef enum logic [3:0] {
    ST_KICK = 4'b0001,
    ST_CAL = 4'b0010,
    ST_LOCK = 4'b0100,
    ST_RUN = 4'b1000
  } cal_state_t;
endpackage

// ### pin_sync.sv
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence is implied between bits.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.sync;
endmodule // pin_sync
`default_nettype wire

// ### cal_lock_model.sv
/*
  Far-side model of the analog calibrator and lock detector.
  Assumes one clock shared with the block; done and lock are levels.
*/
`timescale 1ns/1ns
`default_nettype none
module cal_lock_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cal_start,
  input wire logic i_clear,
  input wire logic i_lose,
  input wire logic [3:0] i_delay,
  output logic o_cal_done,
  output logic o_pll_locked
);
  logic [3:0] cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_cal_start) begin
      cnt_r <= i_delay;
      o_cal_done <= 1'b0;
      o_pll_locked <= 1'b0;
    end else if (i_clear) begin
      // Done must fall before a new trigger, or a stale level ends the run early
      o_cal_done <= 1'b0;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      o_cal_done <= 1'b1;
      o_pll_locked <= o_cal_done && !i_lose;
    end
  end
endmodule // cal_lock_model
`default_nettype wire

// ### test_vco_cal_lock_dither_ctrl.sv
/*
  Self-checking bench for the calibration and lock block.
  Assumes cal_lock_model stands for the analog side.
*/
`timescale 1ns/1ns
`default_nettype none
module test_vco_cal_lock_dither_ctrl;
  import vco_cal_pkg::*;
  logic clk, rst, fwe, vwe, owe, clr, lose, done, lck, cst, tdef, ldo, ldoe_n, sq;
  logic [7:0] fwd, vwd, owd, frd, vrd, ord, w;
  logic [23:0] kdiv;
  logic [24:0] eff;
  logic [3:0] dly;
  logic [31:0] seed;
  int err_count, num_checks;
  vco_cal_lock_dither_ctrl u_vco_cal_lock_dither_ctrl (.i_clk(clk), .i_sys_rst(rst),
    .i_ce(1'b1), .i_frac_ctrl_we(fwe), .i_frac_ctrl_wdata(fwd), .o_frac_ctrl_rdata(frd),
    .i_vco_ctrl_we(vwe), .i_vco_ctrl_wdata(vwd), .o_vco_ctrl_rdata(vrd),
    .i_out_ctrl_we(owe), .i_out_ctrl_wdata(owd), .o_out_ctrl_rdata(ord),
    .i_kdiv_frac(kdiv), .o_kdiv_frac_eff(eff), .i_cal_done(done), .i_pll_locked(lck),
    .o_cal_start(cst), .o_cal_to_default(tdef), .o_lock_indicator_n_o(ldo),
    .o_lock_indicator_n_oe_n(ldoe_n), .o_out_squelch(sq));
  cal_lock_model u_cal_lock_model (.i_clk(clk), .i_rst(rst), .i_cal_start(cst),
    .i_clear(clr), .i_lose(lose), .i_delay(dly), .o_cal_done(done), .o_pll_locked(lck));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [24:0] exp_eff(input logic [23:0] k, input logic [7:0] c);
    return {k, c[5]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic wr(input int r, input logic [7:0] d);
    @(posedge clk);
    fwe <= (r == 0);
    vwe <= (r == 1);
    owe <= (r == 2);
    fwd <= d;
    vwd <= d;
    owd <= d;
    @(posedge clk);
    fwe <= 1'b0;
    vwe <= 1'b0;
    owe <= 1'b0;
    #1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 200 && vrd[0] !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    {rst, fwe, vwe, owe, clr, lose} = 6'h20;
    {fwd, vwd, owd, kdiv} = '0;
    dly = 4'h5;
    seed = 32'hf2bf;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("vco_rd", 8'h01, vrd);
    chk("frac_rd", 8'h00, frd);
    chk("to_def", 1, tdef);
    wait_idle();
    chk("busy", 0, vrd[0]);
    chk("to_def", 0, tdef);
    chk("ld_oe_n", 1, ldoe_n);
    chk("ld_o", 0, ldo);
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      // Last pass flips only the append bit of what was read back
      w = (i == 8) ? (frd ^ 8'h20) : seed[31:24];
      @(posedge clk) kdiv <= seed[23:0];
      // Append is toggled freely here: the model stands in for a closed loop
      wr(0, w);
      chk("frac_rd", w, frd);
      chk("eff", exp_eff(kdiv, w), eff);
    end
    wr(2, 8'h20);
    @(posedge clk) lose <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("ld_oe_n", 0, ldoe_n);
    chk("squelch", 1, sq);
    chk("busy", 0, vrd[0]);
    @(posedge clk) lose <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("ld_oe_n", 1, ldoe_n);
    chk("squelch", 0, sq);
    for (int j = 0; j < 2; j++) begin
      w = j ? 8'h20 : 8'hdf;
      wr(2, w);
      chk("out_rd", w, ord);
      seed = xs(seed);
      @(posedge clk) begin
        clr <= 1'b1;
        dly <= seed[3:0];
      end
      repeat (4) @(posedge clk);
      wr(1, 8'hfe);
      chk("busy", 0, vrd[0]);
      wr(1, 8'h01);
      chk("busy", 1, vrd[0]);
      chk("ld_oe_n", 0, ldoe_n);
      chk("squelch", j, sq);
      @(posedge clk);
      #1;
      chk("cal_start", 1, cst);
      // Zero write lands while the run still waits for done; it must not disturb it
      wr(1, 8'hfe);
      chk("busy", 1, vrd[0]);
      chk("cal_start", 0, cst);
      @(posedge clk) clr <= 1'b0;
      #1;
      chk("busy", 1, vrd[0]);
      wait_idle();
      chk("busy", 0, vrd[0]);
      chk("ld_oe_n", 1, ldoe_n);
      chk("squelch", 0, sq);
    end
    // Second reset after the run has completed: calibration must restart toward the default by itself
    @(posedge clk) begin
      rst <= 1'b1;
      dly <= 4'h5;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("vco_rd", 8'h01, vrd);
    chk("frac_rd", 8'h00, frd);
    chk("to_def", 1, tdef);
    wait_idle();
    chk("busy", 0, vrd[0]);
    chk("to_def", 0, tdef);
    wrap_up();
  end
endmodule // test_vco_cal_lock_dither_ctrl
`default_nettype wire
